// [spef_pkg.sv]
package spef_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the 32-bit bus.
    // ------------------------------------------------------------------
    localparam logic [7:0] SPEF_CTRL_OFS = 8'h14;
    localparam logic [7:0] SPEF_BUF_OFS = 8'h18;
    localparam logic [7:0] SPEF_STAT_OFS = 8'h1C;
    localparam logic [7:0] SPEF_QUEUE_OFS = 8'h20;
    localparam logic [7:0] SPEF_GPIO_OFS = 8'h24;

    // ------------------------------------------------------------------
    // Control register fields and reset value.
    // ------------------------------------------------------------------
    localparam int SPEF_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int SPEF_OVF_BIT = 6;
    localparam int SPEF_EN_BIT = 5;
    localparam int SPEF_CKP_BIT = 4;
    localparam int SPEF_SLAVE_BIT = 2;
    localparam int SPEF_NOSS_BIT = 0;
    localparam logic [7:0] SPEF_CTRL_RST = 8'h00;

    // ------------------------------------------------------------------
    // Status and pin register fields.
    // ------------------------------------------------------------------
    localparam int SPEF_ST_BF_BIT = 0;
    localparam int SPEF_ST_BUSY_BIT = 1;
    localparam int SPEF_ST_QVAL_BIT = 2;
    localparam int SPEF_ST_QFULL_BIT = 3;
    localparam int SPEF_GPIO_OUT_POS = 0;
    localparam int SPEF_GPIO_OE_POS = 4;
    localparam int SPEF_GPIO_IN_POS = 8;
    localparam logic [2:0] SPEF_GPIO_RST = 3'h0;

    // ------------------------------------------------------------------
    // Master clock half periods in system clock cycles, per rate select.
    // ------------------------------------------------------------------
    localparam logic [5:0] SPEF_HALF_DIV0 = 6'h02;
    localparam logic [5:0] SPEF_HALF_DIV1 = 6'h08;
    localparam logic [5:0] SPEF_HALF_DIV2 = 6'h20;

    // ------------------------------------------------------------------
    // Data path sizes.
    // ------------------------------------------------------------------
    localparam int SPEF_BYTE_W = 8;
    localparam int SPEF_QUEUE_DEPTH = 16;

    // The three port pins travel together.
    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdi;
    } spef_pins_t;

endpackage

// [spef_fifo.sv]
module spef_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update.
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; it is only read where the count says valid.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

endmodule // spef_fifo

// [spef_shift.sv]
module spef_shift import spef_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [7:0] load_data_i,
    input wire logic lead_i,
    input wire logic trail_i,
    input wire logic sdi_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_o,
    output logic sdo_o
);
    logic [7:0] sr_r, sr_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic bit_r, bit_nxt, armed_r, armed_nxt, half_r, half_nxt, done_r, done_nxt;

    assign busy_o = armed_r || half_r || (cnt_r != 3'h0);
    assign done_o = done_r;
    assign rx_o = sr_r;
    assign sdo_o = sr_r[7];

    // Sample on the leading edge, shift on the trailing edge.
    always_comb begin
        sr_nxt = sr_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        armed_nxt = armed_r;
        half_nxt = half_r;
        done_nxt = 1'b0;
        if (clear_i) begin
            cnt_nxt = 3'h0;
            armed_nxt = 1'b0;
            half_nxt = 1'b0;
        end else if (load_i) begin
            sr_nxt = load_data_i;
            armed_nxt = 1'b1;
        end else if (lead_i) begin
            bit_nxt = sdi_i;
            half_nxt = 1'b1;
        end else if (trail_i && half_r) begin
            sr_nxt = {sr_r[6:0], bit_r};
            cnt_nxt = cnt_r + 3'h1;
            half_nxt = 1'b0;
            if (cnt_r == 3'h7) begin
                armed_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_r <= 8'h00;
            cnt_r <= 3'h0;
            bit_r <= 1'b0;
            armed_r <= 1'b0;
            half_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            sr_r <= sr_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            armed_r <= armed_nxt;
            half_r <= half_nxt;
            done_r <= done_nxt;
        end
    end

endmodule // spef_shift

// [spef_port.sv]
// Notes on behaviour
// [R1] Buffer write while busy: reject, set collision.
// [R2] Collision flag stays until software clears.
// [R3] New byte over unread byte sets overflow.
// [R4] On overflow keep old byte, drop new.
// [R5] Overflow detectable only in slave mode.
// [R6] Master mode never sets the overflow flag.
// [R7] Slave software reads buffer after every byte.
// [R8] Control bits read/write, zero after reset.
// [R9] Buffer full shows an unread completed reception.
// [R10] Enable hands pins to port, else I/O.
// [R11] Writing zero clears flag; same-cycle event wins.
//
// Implementation choice: the Wishbone interface to the registers.
module spef_port import spef_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire spef_pins_t pin_in_i,
    output spef_pins_t pin_out_o,
    output spef_pins_t pin_oe_o,
    input wire logic ss_n_i
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] buf_r, buf_nxt;
    logic bf_r, bf_nxt;
    logic [2:0] gpio_out_r, gpio_out_nxt, gpio_oe_r, gpio_oe_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    spef_pins_t pout_r, pout_nxt, poe_r, poe_nxt;
    spef_pins_t pin_s1_r, pin_s2_r, pin_s3_r;
    logic ss_s1_r, ss_s2_r;
    logic sck_r, sck_nxt;
    logic [5:0] div_r, div_nxt;
    logic en, slave, cpol, ss_ok, req, is_queue, acc, wr, rd;
    logic wr_ctrl, wr_buf, rd_buf, wr_gpio, wr_queue;
    logic busy, done, sdo, load, q_ready, q_valid, q_pop;
    logic [7:0] rx, q_data, load_data;
    logic tick, lead, trail;
    logic set_write_collision_flag, set_ovf;
    logic [5:0] half_div;

    // Control fields in use by the port logic.
    assign en = ctrl_r[SPEF_EN_BIT];
    assign slave = ctrl_r[SPEF_SLAVE_BIT];
    assign cpol = ctrl_r[SPEF_CKP_BIT];
    // Slave select gates a slave only in the mode that uses the pin.
    assign ss_ok = ctrl_r[SPEF_NOSS_BIT] || !ss_s2_r;

    // ------------------------------------------------------------------
    // Wishbone decode.
    // ------------------------------------------------------------------
    // A queue write waits for room, so a full queue stalls the master.
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign is_queue = (wb_adr_i == SPEF_QUEUE_OFS);
    assign acc = req && !(is_queue && wb_we_i && !q_ready);
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;
    assign wr_ctrl = wr && (wb_adr_i == SPEF_CTRL_OFS);
    assign wr_buf = wr && (wb_adr_i == SPEF_BUF_OFS);
    assign rd_buf = rd && (wb_adr_i == SPEF_BUF_OFS);
    assign wr_gpio = wr && (wb_adr_i == SPEF_GPIO_OFS);
    assign wr_queue = wr && is_queue;

    // ------------------------------------------------------------------
    // Transmit queue in front of the shifter.
    // ------------------------------------------------------------------
    // The queue drains only into an idle enabled master; a direct
    // buffer write in the same cycle has priority over it.
    assign q_pop = q_valid && en && !slave && !busy && !wr_buf;

    spef_fifo #(
        .WIDTH(SPEF_BYTE_W),
        .DEPTH(SPEF_QUEUE_DEPTH)
    ) u_queue (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_queue),
        .in_ready_o(q_ready),
        .in_data_i(wb_dat_i[7:0]),
        .out_valid_o(q_valid),
        .out_ready_i(q_pop),
        .out_data_o(q_data)
    );

    // ------------------------------------------------------------------
    // Shifter load and error events.
    // ------------------------------------------------------------------
    // A write that meets a busy shifter is dropped and only flagged.
    assign set_write_collision_flag = wr_buf && busy; // [R1]
    assign load = (wr_buf && !busy && en) || q_pop; // [R1]
    assign load_data = wr_buf ? wb_dat_i[7:0] : q_data;
    // Overflow needs slave mode and an unread byte not read right now.
    assign set_ovf = done && slave && bf_r && !rd_buf; // [R3] [R5] [R6]

    spef_shift u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!en),
        .load_i(load),
        .load_data_i(load_data),
        .lead_i(lead),
        .trail_i(trail),
        .sdi_i(pin_s2_r.sdi),
        .busy_o(busy),
        .done_o(done),
        .rx_o(rx),
        .sdo_o(sdo)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    // Two stages before use; the third stage feeds only edge detection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            ss_s1_r <= 1'b1;
            ss_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= pin_in_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            ss_s1_r <= ss_n_i;
            ss_s2_r <= ss_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Serial clock: master divider or slave edge detection.
    // ------------------------------------------------------------------
    // Rate select picks the half period of the generated clock.
    always_comb begin
        unique case (ctrl_r[1:0])
            2'h0: half_div = SPEF_HALF_DIV0;
            2'h1: half_div = SPEF_HALF_DIV1;
            default: half_div = SPEF_HALF_DIV2;
        endcase
    end

    assign tick = en && !slave && busy && (div_r == half_div - 6'h01);

    // Leading edge leaves the idle level, trailing edge returns to it.
    always_comb begin
        lead = 1'b0;
        trail = 1'b0;
        if (en && !slave) begin
            lead = tick && (sck_r == cpol);
            trail = tick && (sck_r != cpol);
        end else if (en && slave && ss_ok && (pin_s2_r.sck != pin_s3_r.sck)) begin
            lead = (pin_s2_r.sck != cpol);
            trail = (pin_s2_r.sck == cpol);
        end
    end

    // The divider restarts whenever the master is idle, so the first
    // half period after a load is always a full one.
    always_comb begin
        div_nxt = 6'h00;
        sck_nxt = cpol;
        if (en && !slave && busy) begin
            div_nxt = tick ? 6'h00 : div_r + 6'h01;
            sck_nxt = tick ? !sck_r : sck_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= 6'h00;
            sck_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            sck_r <= sck_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control register with its two error flags.
    // ------------------------------------------------------------------
    // Software may write every bit; a hardware event on a flag wins
    // over a same-cycle write of zero, and nothing else clears a flag.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = wb_dat_i[7:0]; // [R8] [R11]
        end
        if (set_write_collision_flag) begin
            ctrl_nxt[SPEF_WRITE_COLLISION_FLAG_BIT] = 1'b1; // [R1] [R2] [R11]
        end
        if (set_ovf) begin
            ctrl_nxt[SPEF_OVF_BIT] = 1'b1; // [R3] [R2] [R11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= SPEF_CTRL_RST; // [R8]
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Transfer buffer and buffer full flag.
    // ------------------------------------------------------------------
    // On overflow the held byte stays and the shifted byte is lost.
    // A master always takes the new byte, since software paced it.
    always_comb begin
        buf_nxt = buf_r;
        bf_nxt = bf_r;
        if (rd_buf) begin
            bf_nxt = 1'b0; // [R9]
        end
        if (done && !set_ovf) begin
            buf_nxt = rx; // [R4] [R6]
            bf_nxt = 1'b1; // [R9]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_r <= 8'h00;
            bf_r <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            bf_r <= bf_nxt;
        end
    end

    // ------------------------------------------------------------------
    // General purpose pin registers.
    // ------------------------------------------------------------------
    always_comb begin
        gpio_out_nxt = gpio_out_r;
        gpio_oe_nxt = gpio_oe_r;
        if (wr_gpio) begin
            gpio_out_nxt = wb_dat_i[SPEF_GPIO_OUT_POS +: 3];
            gpio_oe_nxt = wb_dat_i[SPEF_GPIO_OE_POS +: 3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio_out_r <= SPEF_GPIO_RST;
            gpio_oe_r <= SPEF_GPIO_RST;
        end else begin
            gpio_out_r <= gpio_out_nxt;
            gpio_oe_r <= gpio_oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin ownership.
    // ------------------------------------------------------------------
    // An enabled port owns all three pins; otherwise the pin registers
    // drive them. A deselected slave releases its data output so that
    // several slaves can share one line.
    always_comb begin
        pout_nxt = spef_pins_t'(gpio_out_r);
        poe_nxt = spef_pins_t'(gpio_oe_r);
        if (en) begin
            pout_nxt.sck = sck_r; // [R10]
            pout_nxt.sdo = sdo; // [R10]
            pout_nxt.sdi = 1'b0;
            poe_nxt.sck = !slave; // [R10]
            poe_nxt.sdo = !slave || ss_ok; // [R10]
            poe_nxt.sdi = 1'b0; // [R10]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pout_r <= '0;
            poe_r <= '0;
        end else begin
            pout_r <= pout_nxt;
            poe_r <= poe_nxt;
        end
    end

    assign pin_out_o = pout_r;
    assign pin_oe_o = poe_r;

    // ------------------------------------------------------------------
    // Wishbone answer.
    // ------------------------------------------------------------------
    // Ack follows one cycle after an accepted request; unmapped
    // addresses answer with zero and writes to them are ignored.
    always_comb begin
        ack_nxt = acc;
        dat_nxt = 32'h0000_0000;
        if (rd) begin
            unique case (wb_adr_i)
                SPEF_CTRL_OFS: dat_nxt[7:0] = ctrl_r; // [R8]
                SPEF_BUF_OFS: dat_nxt[7:0] = buf_r;
                SPEF_STAT_OFS: begin
                    dat_nxt[SPEF_ST_BF_BIT] = bf_r; // [R9]
                    dat_nxt[SPEF_ST_BUSY_BIT] = busy;
                    dat_nxt[SPEF_ST_QVAL_BIT] = q_valid;
                    dat_nxt[SPEF_ST_QFULL_BIT] = !q_ready;
                end
                SPEF_GPIO_OFS: begin
                    dat_nxt[SPEF_GPIO_OUT_POS +: 3] = gpio_out_r;
                    dat_nxt[SPEF_GPIO_OE_POS +: 3] = gpio_oe_r;
                    dat_nxt[SPEF_GPIO_IN_POS +: 3] = pin_s2_r;
                end
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule // spef_port

// [spef_port_assertions.sv]
module spef_port_assertions import spef_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire spef_pins_t pin_in_i,
    input wire spef_pins_t pin_out_o,
    input wire spef_pins_t pin_oe_o,
    input wire logic ss_n_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------
    // Shadow of software's view
    // ------
    logic [5:0] ctrl_r, ctrl_nxt, ctrl_d_r;
    logic [2:0] gpoe_r, gpoe_nxt;
    logic write_collision_flag_r, write_collision_flag_nxt, ovf_r, ovf_nxt;
    logic wr_ok, rd_ctrl, stable_w;
    assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ctrl = wb_ack_o && !wb_we_i && wb_adr_i == SPEF_CTRL_OFS;
    assign stable_w = ctrl_r == ctrl_d_r;

    // Overflow may only be set once slave mode was seen; it stays possible until cleared.
    always_comb begin
        ctrl_nxt = ctrl_r;
        gpoe_nxt = gpoe_r;
        write_collision_flag_nxt = write_collision_flag_r | (rd_ctrl && wb_dat_o[SPEF_WRITE_COLLISION_FLAG_BIT]);
        ovf_nxt = ovf_r | ctrl_r[SPEF_SLAVE_BIT];
        if (wr_ok && wb_adr_i == SPEF_CTRL_OFS) begin
            ctrl_nxt = wb_dat_i[5:0];
            write_collision_flag_nxt = wb_dat_i[7];
            ovf_nxt = wb_dat_i[6] | wb_dat_i[2] | ctrl_r[SPEF_SLAVE_BIT];
        end
        if (wr_ok && wb_adr_i == SPEF_GPIO_OFS) begin
            gpoe_nxt = wb_dat_i[6:4];
        end
    end

    // Registers the shadow; all of it clears with reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 6'h00;
            ctrl_d_r <= 6'h00;
            gpoe_r <= 3'h0;
            write_collision_flag_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ctrl_d_r <= ctrl_r;
            gpoe_r <= gpoe_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // ------
    // Checks
    // ------
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        wb_adr_i != SPEF_QUEUE_OFS |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i)
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && pin_oe_o == 3'h0) else $error("outputs active in reset");
    a_ctrl_readback: assert property (rd_ctrl |-> wb_dat_o[5:0] == ctrl_r)
        else $error("control readback differs");
    a_write_collision_flag_sticky: assert property (rd_ctrl && write_collision_flag_r |-> wb_dat_o[SPEF_WRITE_COLLISION_FLAG_BIT])
        else $error("collision flag lost");
    a_ovf_master: assert property (rd_ctrl && !ovf_r |-> !wb_dat_o[SPEF_OVF_BIT])
        else $error("overflow set in master mode");
    a_pins_io: assert property (!ctrl_r[SPEF_EN_BIT] && stable_w |->
        pin_oe_o == spef_pins_t'(gpoe_r)) else $error("pins not released");
    a_pins_master: assert property (ctrl_r[SPEF_EN_BIT] && !ctrl_r[SPEF_SLAVE_BIT] &&
        stable_w |-> pin_oe_o == 3'h6) else $error("master pins not driven");

    c_ovf_seen: cover property (rd_ctrl && wb_dat_o[SPEF_OVF_BIT]);
    c_write_collision_flag_seen: cover property (rd_ctrl && wb_dat_o[SPEF_WRITE_COLLISION_FLAG_BIT]);
    c_queue_push: cover property (wr_ok && wb_adr_i == SPEF_QUEUE_OFS);
endmodule // spef_port_assertions

// [spef_spi_peer.sv]
module spef_spi_peer (
    input wire logic sck_i,
    input wire logic sdo_i,
    output logic sck_o,
    output logic sdi_o,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lclk = 1'b0;
    initial sck_o = 1'b0;
    initial sdi_o = 1'b0;
    initial rx_o = 8'h00;

    // Link clock of 80 ns, offset so its edges never meet the system clock's.
    initial begin
        #3;
        forever #40 lclk = ~lclk;
    end

    // Captures the wire's data out on every leading clock edge, MSB first.
    always @(posedge sck_i) rx_o <= {rx_o[6:0], sdo_i};

    // One byte as master: data set on trailing edge, clock idles low between frames.
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge lclk);
            sck_o = 1'b0;
            sdi_o = b[i];
            @(posedge lclk);
            sck_o = 1'b1;
        end
        @(negedge lclk);
        sck_o = 1'b0;
        sdi_o = ~sdi_o; // Released line shows the inverse, so a stale bit is never reused.
    endtask
endmodule // spef_spi_peer

// [spi_port_error_flags_test.sv]
module spi_port_error_flags_test import spef_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic psck, psdi;
    logic [7:0] prx;
    spef_pins_t p_out, p_oe, p_in;
    int err_total = 0;
    int tests_run = 0;
    logic [7:0] rw_vals [3] = '{8'hD3, 8'h0C, 8'h00};

    always #5 clk = ~clk;

    // Wire levels: a pin that the port does not drive shows the peer, or a pull-up on data out.
    assign p_in = {p_oe.sck ? p_out.sck : psck, p_oe.sdo ? p_out.sdo : 1'b1,
        p_oe.sdi ? p_out.sdi : psdi};

    spef_spi_peer PEER (.sck_i(p_in.sck), .sdo_i(p_in.sdo), .sck_o(psck), .sdi_o(psdi),
        .rx_o(prx));
    spef_port DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_in_i(p_in), .pin_out_o(p_out), .pin_oe_o(p_oe), .ss_n_i(1'b1));

    // ------
    // Bus tasks and checks
    // ------
    task automatic tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Classic cycle held until ack is sampled; the bound only cuts a hang.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 500) begin
            n++;
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 500) begin
            chk(32'h1, 32'h0);
            tally_and_finish();
        end
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    // Polls a register bit, bounded.
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        xfer(1'b0, a, 8'h00);
        while (q[b] !== v && n < 500) begin
            n++;
            xfer(1'b0, a, 8'h00);
        end
        chk(q[b], v);
        // A poll that never saw the level has already counted; stop here.
        if (q[b] !== v) tally_and_finish();
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(SPEF_CTRL_OFS, 32'h00);
        rd(SPEF_STAT_OFS, 32'h00);
        rd(8'h30, 32'h00);
        chk(p_oe, 3'h0);
        foreach (rw_vals[i]) begin
            xfer(1'b1, SPEF_CTRL_OFS, rw_vals[i]);
            rd(SPEF_CTRL_OFS, {24'h0, rw_vals[i]});
        end
        // Disabled port leaves the pins to the pin register.
        xfer(1'b1, SPEF_GPIO_OFS, 8'h75);
        chk(p_out, 3'h5);
        rd(SPEF_STAT_OFS, 32'h00);
        rd(SPEF_GPIO_OFS, 32'h575);
        xfer(1'b1, SPEF_GPIO_OFS, 8'h00);
        // Master: a second buffer write lands while the first byte is still shifting.
        xfer(1'b1, SPEF_CTRL_OFS, 8'h20);
        chk(p_oe, 3'h6);
        xfer(1'b1, SPEF_BUF_OFS, 8'hA5);
        xfer(1'b1, SPEF_BUF_OFS, 8'h3C);
        wait_bit(SPEF_STAT_OFS, SPEF_ST_BUSY_BIT, 1'b0);
        rd(SPEF_CTRL_OFS, 32'hA0);
        chk(prx, 8'hA5);
        xfer(1'b1, SPEF_CTRL_OFS, 8'hA1);
        xfer(1'b1, SPEF_BUF_OFS, 8'h0F);
        wait_bit(SPEF_STAT_OFS, SPEF_ST_BUSY_BIT, 1'b0);
        rd(SPEF_CTRL_OFS, 32'hA1);
        chk(prx, 8'h0F);
        xfer(1'b1, SPEF_CTRL_OFS, 8'h20);
        rd(SPEF_CTRL_OFS, 32'h20);
        rd(SPEF_BUF_OFS, 32'h00);
        rd(SPEF_STAT_OFS, 32'h00);
        // Slave: second byte arrives before the first was read.
        xfer(1'b1, SPEF_CTRL_OFS, 8'h25);
        PEER.send(8'h5A);
        wait_bit(SPEF_STAT_OFS, SPEF_ST_BF_BIT, 1'b1);
        PEER.send(8'hC3);
        wait_bit(SPEF_CTRL_OFS, SPEF_OVF_BIT, 1'b1);
        rd(SPEF_BUF_OFS, 32'h5A);
        rd(SPEF_STAT_OFS, 32'h00);
        xfer(1'b1, SPEF_CTRL_OFS, 8'h25);
        for (int i = 1; i < 3; i++) begin
            PEER.send(8'(i * 17));
            wait_bit(SPEF_STAT_OFS, SPEF_ST_BF_BIT, 1'b1);
            rd(SPEF_BUF_OFS, i * 17);
        end
        rd(SPEF_CTRL_OFS, 32'h25);
        // Queue: fill while disabled, then drain through master transfers.
        xfer(1'b1, SPEF_CTRL_OFS, 8'h00);
        for (int i = 0; i < 16; i++) xfer(1'b1, SPEF_QUEUE_OFS, 8'(i));
        rd(SPEF_STAT_OFS, 32'h0C);
        xfer(1'b1, SPEF_CTRL_OFS, 8'h20);
        wait_bit(SPEF_STAT_OFS, SPEF_ST_QVAL_BIT, 1'b0);
        wait_bit(SPEF_STAT_OFS, SPEF_ST_BUSY_BIT, 1'b0);
        chk(prx, 8'h0F);
        tally_and_finish();
    end
endmodule // spi_port_error_flags_test

bind spef_port spef_port_assertions CHK (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .ss_n_i(ss_n_i));
